// File: rtl/gwe_echo_if.sv
// Bundle between the register core and the echo output stage.
// Assumes one clock domain; all members are plain levels.
`timescale 1ns/1ps
`default_nettype none

interface gwe_echo_if #(
  parameter int PAIRS = 10
);
  logic [PAIRS-1:0] enable;     // Echo enables from software
  logic [PAIRS-1:0] dest_gpio;  // Destination pin in GPIO function
  logic [PAIRS-1:0] src_level;  // Synchronised source levels
  logic [PAIRS-1:0] out_data;   // Output data register values
  logic [PAIRS-1:0] pin_out;    // Resulting pin drive

  modport core  (output enable, output dest_gpio, output src_level, output out_data,
                 input pin_out);
  modport stage (input enable, input dest_gpio, input src_level, input out_data,
                 output pin_out);
endinterface

`default_nettype wire

// File: rtl/gwe_echo_stage.sv
// Echo output stage: per pair, drives the synchronised source onto the
// destination when echo is on and the pin is in GPIO function.
// Assumes src_level already synchronised to clk_i.
`timescale 1ns/1ps
`default_nettype none

module gwe_echo_stage #(
  parameter int PAIRS = 10
) (
  input  wire logic  clk_i,    // Core clock
  input  wire logic  rst_n_i,  // Async reset, active low
  gwe_echo_if.stage  echo      // Echo bundle
);

  logic [PAIRS-1:0] pin_nxt;

  always_comb begin
    for (int i = 0; i < PAIRS; i++) begin
      if (echo.enable[i] && echo.dest_gpio[i]) begin
        pin_nxt[i] = echo.src_level[i];
      end else begin
        pin_nxt[i] = echo.out_data[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      echo.pin_out <= '0;
    end else begin
      echo.pin_out <= pin_nxt;
    end
  end

endmodule

`default_nettype wire

// File: rtl/gwe_pkg.sv
// Types shared by the wake-interrupt and echo configuration block.
// Assumes nothing of its surroundings.
package gwe_pkg;

  typedef logic [7:0] gwe_byte_t;

  // Avalon read answer sequencing
  typedef enum logic [0:0] {
    GWE_BUS_IDLE = 1'b0,
    GWE_BUS_RESP = 1'b1
  } gwe_bus_e;

endpackage

// File: rtl/gwe_regs.svh
// Register map, field positions, reset values and timing figures of the
// wake-interrupt and echo configuration block.
// Assumes inclusion by bare name from rtl/; definitions only.
`ifndef GWE_REGS_SVH
`define GWE_REGS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define GWE_IDX_EXT_IRQ_CONFIG  16'hFF00
`define GWE_IDX_ECHO_ENABLE_ONE 16'hFF02
`define GWE_IDX_ECHO_ENABLE_TWO 16'hFF04
`define GWE_IDX_IRQ_STATUS      16'hFF06
`define GWE_IDX_IRQ_MASK        16'hFF08

// ****************************************************************
// Reset values
// ****************************************************************
`define GWE_RST_EXT_IRQ_CONFIG  8'h00
`define GWE_RST_ECHO_ENABLE     8'h00
`define GWE_RST_IRQ_STATUS      8'h00
`define GWE_RST_IRQ_MASK        8'h00

// ****************************************************************
// Field positions and widths
// ****************************************************************
`define GWE_BIT_FIRST_WAKE      0
`define GWE_BIT_SECOND_WAKE     1
`define GWE_EXT_CFG_USED        2
`define GWE_ECHO_BITS_PER_REG   5
`define GWE_ECHO_PAIRS          10
`define GWE_STAT_ALT_BASE       2
`define GWE_REG_WIDTH           8

// Echo source lane that carries each wake input
`define GWE_SRC_FIRST_WAKE      1
`define GWE_SRC_SECOND_WAKE     2

// ****************************************************************
// Timing: period in ps, echo latency bound in ns
// ****************************************************************
`define GWE_CLK_PERIOD_PS       10000
`define GWE_ECHO_MAX_NS         20
`define GWE_ECHO_MAX_CYC        ((`GWE_ECHO_MAX_NS * 1000) / `GWE_CLK_PERIOD_PS)

`endif

// File: rtl/gwe_sync.sv
// Two-stage synchroniser for a vector of pin levels.
// Assumes the inputs are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

module gwe_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,    // Core clock
  input  wire logic         rst_n_i,  // Async reset, active low
  input  wire logic [W-1:0] async_i,  // Pin levels
  output logic      [W-1:0] sync_o    // Synchronised levels
);

  logic [W-1:0] meta_r;

  initial begin
    if (W < 1) begin
      $error("gwe_sync: width must be at least one");
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

`default_nettype wire

// File: rtl/gwe_top.sv
// Wake-interrupt and echo configuration block with Avalon-MM register slave.
// Assumes pin levels arrive asynchronously and are synchronised here;
// pin function selects and output data come from the GPIO port logic.
//
// Overview of operation
// [R01] The external interrupt configuration register is a byte read/write register reset to 00.
// [R02] Its bits act on a wake pin only while that pin is in its GPIO function.
// [R03] Bit 0 opens the first wake input for change interrupts; clear blocks it except GPIO reads.
// [R04] Bit 1 opens the second wake input for change interrupts; clear blocks it likewise.
// [R05] Pins with an input alternate function get their interrupt enabled when it is selected.
// [R06] Certain GPIO inputs can be paired with outputs that echo them under software mask.
// [R07] Echo sources are wake-capable GPIO inputs and destinations are echo-capable outputs.
// [R08] An input is echoed to its paired output only while that pair's enable bit is set.
// [R09] Software should enable the interrupt function of a source whose echo it intends.
// [R10] Echo enable one bits 0-4 route C4,E6,E7,F6,F7 onto A0-A4; bits 7-5 reserved.
// [R11] Echo enable two bits 0-4 route D0,D1,C6 to B0-B2, D2 to D3 and E4 to C0.
// [R12] Echo enable bits act only while the destination pin is in its GPIO function.
// [R13] Both echo enable registers are byte read/write registers reset to 00.
// [R14] With echo on, the destination follows the synchronised source within two cycles.
//
// Added by the designer: the Avalon-MM register port.
`include "gwe_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module gwe_top #(
  parameter int N_ALT = 2
) (
  input  wire logic              clk_i,             // Core clock, 100 MHz
  input  wire logic              rst_n_i,           // Async reset, active low
  // Avalon-MM slave
  input  wire logic [17:0]       avs_address,       // Byte address
  input  wire logic              avs_read,          // Read request
  input  wire logic              avs_write,         // Write request
  input  wire logic [31:0]       avs_writedata,     // Write data
  input  wire logic [3:0]        avs_byteenable,    // Byte lanes
  output logic      [31:0]       avs_readdata,      // Read data
  output logic                   avs_waitrequest,   // Stall
  // Interrupt
  output logic                   irq_o,             // Level, high while unmasked event pending
  // Echo-capable pins, lane order of the pairing table
  input  wire logic [9:0]        echo_src_pin_i,    // Source pin levels
  input  wire logic [9:0]        echo_dest_gpio_i,  // Destination in GPIO function
  input  wire logic [9:0]        echo_out_data_i,   // Destination output data register
  output logic      [9:0]        echo_pin_o,        // Destination pin drive
  output logic      [9:0]        echo_src_gpio_o,   // Source levels for GPIO reads
  // Wake inputs under configuration register control
  input  wire logic [1:0]        wake_gpio_func_i,  // Wake pin in GPIO function
  output logic      [1:0]        wake_open_o,       // Wake input passed to detector
  output logic      [1:0]        wake_level_o,      // Gated wake level, 0 when blocked
  // Wake pins with an input alternate function
  input  wire logic [N_ALT-1:0]  alt_pin_i,         // Pin levels
  input  wire logic [N_ALT-1:0]  alt_func_sel_i,    // Alternate function selected
  output logic      [N_ALT-1:0]  alt_irq_en_o       // Interrupt function enabled
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  initial begin
    if (N_ALT < 1 || N_ALT > (`GWE_REG_WIDTH - `GWE_STAT_ALT_BASE)) begin
      $error("gwe_top: N_ALT must lie between 1 and 6");
    end
  end

  localparam int PAIRS = `GWE_ECHO_PAIRS;
  localparam int NSYNC = PAIRS + N_ALT;
  localparam int ECHO_MAX_CYC = (`GWE_ECHO_MAX_CYC < 1) ? 1 : `GWE_ECHO_MAX_CYC;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic hit(input logic [17:0] addr, input logic [15:0] idx);
    hit = (addr == {idx, 2'b00});
  endfunction

  function automatic gwe_pkg::gwe_byte_t merge(input gwe_pkg::gwe_byte_t old_v,
                                               input gwe_pkg::gwe_byte_t new_v,
                                               input gwe_pkg::gwe_byte_t keep);
    merge = (old_v & ~keep) | (new_v & keep);
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [NSYNC-1:0] pin_sync;
  logic [PAIRS-1:0] src_sync;
  logic [N_ALT-1:0] alt_sync;

  gwe_sync #(
    .W (NSYNC)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i ({alt_pin_i, echo_src_pin_i}),
    .sync_o  (pin_sync)
  );

  assign src_sync = pin_sync[PAIRS-1:0];
  assign alt_sync = pin_sync[NSYNC-1:PAIRS];

  // GPIO reads always see the pin, open or blocked
  assign echo_src_gpio_o = src_sync;

  // ****************************************************************
  // Avalon-MM access decode
  // ****************************************************************
  gwe_pkg::gwe_bus_e bus_state_r;
  gwe_pkg::gwe_bus_e bus_state_nxt;
  logic              wr_take;
  logic              lane0;
  gwe_pkg::gwe_byte_t wdata;
  logic              hit_cfg;
  logic              hit_one;
  logic              hit_two;
  logic              hit_stat;
  logic              hit_mask;

  assign lane0    = avs_byteenable[0];
  assign wdata    = avs_writedata[7:0];
  assign hit_cfg  = hit(avs_address, `GWE_IDX_EXT_IRQ_CONFIG);
  assign hit_one  = hit(avs_address, `GWE_IDX_ECHO_ENABLE_ONE);
  assign hit_two  = hit(avs_address, `GWE_IDX_ECHO_ENABLE_TWO);
  assign hit_stat = hit(avs_address, `GWE_IDX_IRQ_STATUS);
  assign hit_mask = hit(avs_address, `GWE_IDX_IRQ_MASK);

  // Writes complete at once; reads wait one cycle for registered data
  assign wr_take         = avs_write && !avs_read;
  assign avs_waitrequest = avs_read && (bus_state_r == gwe_pkg::GWE_BUS_IDLE);

  always_comb begin
    case (bus_state_r)
      gwe_pkg::GWE_BUS_IDLE: begin
        bus_state_nxt = avs_read ? gwe_pkg::GWE_BUS_RESP : gwe_pkg::GWE_BUS_IDLE;
      end
      gwe_pkg::GWE_BUS_RESP: begin
        bus_state_nxt = gwe_pkg::GWE_BUS_IDLE;
      end
      default: begin
        bus_state_nxt = gwe_pkg::GWE_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_state_r <= gwe_pkg::GWE_BUS_IDLE;
    end else begin
      bus_state_r <= bus_state_nxt;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  gwe_pkg::gwe_byte_t ext_irq_config_r;
  gwe_pkg::gwe_byte_t echo_enable_one_r;
  gwe_pkg::gwe_byte_t echo_enable_two_r;
  gwe_pkg::gwe_byte_t irq_mask_r;

  localparam gwe_pkg::gwe_byte_t CFG_KEEP  = 8'h03;
  localparam gwe_pkg::gwe_byte_t ECHO_KEEP = 8'h1F;
  localparam gwe_pkg::gwe_byte_t STAT_KEEP = 8'(((1 << (`GWE_STAT_ALT_BASE + N_ALT)) - 1));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_irq_config_r <= `GWE_RST_EXT_IRQ_CONFIG;  // R01
    end else if (wr_take && lane0 && hit_cfg) begin
      ext_irq_config_r <= merge(ext_irq_config_r, wdata, CFG_KEEP);  // R01
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      echo_enable_one_r <= `GWE_RST_ECHO_ENABLE;  // R13
      echo_enable_two_r <= `GWE_RST_ECHO_ENABLE;  // R13
    end else if (wr_take && lane0) begin
      if (hit_one) begin
        echo_enable_one_r <= merge(echo_enable_one_r, wdata, ECHO_KEEP);  // R10
      end
      if (hit_two) begin
        echo_enable_two_r <= merge(echo_enable_two_r, wdata, ECHO_KEEP);  // R11
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask_r <= `GWE_RST_IRQ_MASK;
    end else if (wr_take && lane0 && hit_mask) begin
      irq_mask_r <= merge(irq_mask_r, wdata, STAT_KEEP);
    end
  end

  // ****************************************************************
  // Wake input gating and change detection
  // ****************************************************************
  logic [1:0]       wake_sync;
  logic [1:0]       wake_open;
  logic [1:0]       wake_prev_r;
  logic [N_ALT-1:0] alt_prev_r;
  logic [1:0]       wake_evt;
  logic [N_ALT-1:0] alt_evt;

  assign wake_sync = {src_sync[`GWE_SRC_SECOND_WAKE], src_sync[`GWE_SRC_FIRST_WAKE]};

  // Open only with the enable bit set and the pin in GPIO function
  assign wake_open[0] = ext_irq_config_r[`GWE_BIT_FIRST_WAKE]
                        && wake_gpio_func_i[0];  // R02 R03
  assign wake_open[1] = ext_irq_config_r[`GWE_BIT_SECOND_WAKE]
                        && wake_gpio_func_i[1];  // R02 R04

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_prev_r  <= '0;
      alt_prev_r   <= '0;
      wake_open_o  <= '0;
      wake_level_o <= '0;
      alt_irq_en_o <= '0;
    end else begin
      wake_prev_r  <= wake_sync;
      alt_prev_r   <= alt_sync;
      wake_open_o  <= wake_open;                 // R03 R04
      wake_level_o <= wake_sync & wake_open;     // R03 R04
      alt_irq_en_o <= alt_func_sel_i;            // R05
    end
  end

  assign wake_evt = (wake_sync ^ wake_prev_r) & wake_open;  // R03 R04
  assign alt_evt  = (alt_sync ^ alt_prev_r) & alt_func_sel_i;  // R05

  // ****************************************************************
  // Interrupt status, write one to clear, set wins
  // ****************************************************************
  gwe_pkg::gwe_byte_t irq_status_r;
  gwe_pkg::gwe_byte_t irq_set;
  gwe_pkg::gwe_byte_t irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[`GWE_BIT_FIRST_WAKE]  = wake_evt[0];
    irq_set[`GWE_BIT_SECOND_WAKE] = wake_evt[1];
    irq_set[`GWE_STAT_ALT_BASE +: N_ALT] = alt_evt;
  end

  assign irq_clr = (wr_take && lane0 && hit_stat) ? (wdata & STAT_KEEP) : 8'h00;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_status_r <= `GWE_RST_IRQ_STATUS;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
    end
  end

  assign irq_o = |(irq_status_r & irq_mask_r);

  // ****************************************************************
  // Echo routing
  // ****************************************************************
  gwe_echo_if #(.PAIRS(PAIRS)) echo_bus ();

  // Lanes 0-4 pair with enable one, lanes 5-9 with enable two
  assign echo_bus.enable    = {echo_enable_two_r[4:0], echo_enable_one_r[4:0]};  // R08 R10 R11
  assign echo_bus.dest_gpio = echo_dest_gpio_i;   // R12
  assign echo_bus.src_level = src_sync;           // R06 R07
  assign echo_bus.out_data  = echo_out_data_i;
  assign echo_pin_o         = echo_bus.pin_out;   // R14

  gwe_echo_stage #(
    .PAIRS (PAIRS)
  ) u_echo (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .echo    (echo_bus)
  );

  initial begin
    if (ECHO_MAX_CYC < 1) begin
      $error("gwe_top: echo latency bound below one cycle");
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  gwe_pkg::gwe_byte_t rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (hit_cfg) begin
      rd_byte = ext_irq_config_r;
    end else if (hit_one) begin
      rd_byte = echo_enable_one_r;
    end else if (hit_two) begin
      rd_byte = echo_enable_two_r;
    end else if (hit_stat) begin
      rd_byte = irq_status_r;
    end else if (hit_mask) begin
      rd_byte = irq_mask_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && bus_state_r == gwe_pkg::GWE_BUS_IDLE) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

endmodule

`default_nettype wire

// File: tb/gwe_top_props.sv
// Checker for the wake-interrupt and echo configuration block.
// Assumes it sees only the top ports; shadows registers from bus writes.
`include "gwe_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module gwe_top_props #(
  parameter int N_ALT = 2
) (
  input wire logic             clk_i,            // Clock
  input wire logic             rst_n_i,          // Reset
  input wire logic [17:0]      avs_address,      // Address
  input wire logic             avs_read,         // Read
  input wire logic             avs_write,        // Write
  input wire logic [31:0]      avs_writedata,    // Write data
  input wire logic [3:0]       avs_byteenable,   // Lanes
  input wire logic [31:0]      avs_readdata,     // Read data
  input wire logic             avs_waitrequest,  // Stall
  input wire logic             irq_o,            // Interrupt
  input wire logic [9:0]       echo_src_pin_i,   // Sources
  input wire logic [9:0]       echo_dest_gpio_i, // Dest GPIO
  input wire logic [9:0]       echo_out_data_i,  // Out data
  input wire logic [9:0]       echo_pin_o,       // Pin drive
  input wire logic [9:0]       echo_src_gpio_o,  // Synced
  input wire logic [1:0]       wake_gpio_func_i, // Wake GPIO
  input wire logic [1:0]       wake_open_o,      // Wake open
  input wire logic [1:0]       wake_level_o,     // Wake level
  input wire logic [N_ALT-1:0] alt_func_sel_i,   // Alt select
  input wire logic [N_ALT-1:0] alt_irq_en_o      // Alt enable
);
  localparam logic [17:0] A_CFG = {`GWE_IDX_EXT_IRQ_CONFIG, 2'b00};
  localparam logic [17:0] A_E1  = {`GWE_IDX_ECHO_ENABLE_ONE, 2'b00};
  localparam logic [17:0] A_E2  = {`GWE_IDX_ECHO_ENABLE_TWO, 2'b00};
  localparam logic [17:0] A_STA = {`GWE_IDX_IRQ_STATUS, 2'b00};
  localparam logic [17:0] A_MSK = {`GWE_IDX_IRQ_MASK, 2'b00};
  logic [1:0]  cfg_r;
  logic [9:0]  en_r;
  logic [7:0]  mask_r;
  logic        wr;
  logic        rd_chk;
  logic [31:0] rd_exp;
  logic [9:0]  sel;
  // ****************************************************************
  // Register shadows
  // ****************************************************************
  assign wr = avs_write && !avs_read && avs_byteenable[0];
  assign sel = en_r & echo_dest_gpio_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r <= 2'h0;
      en_r <= 10'h0;
      mask_r <= 8'h00;
    end else if (wr) begin
      if (avs_address == A_CFG) cfg_r <= avs_writedata[1:0];
      if (avs_address == A_E1) en_r[4:0] <= avs_writedata[4:0];
      if (avs_address == A_E2) en_r[9:5] <= avs_writedata[4:0];
      if (avs_address == A_MSK) mask_r <= avs_writedata[7:0];
    end
  end
  always_comb begin
    rd_chk = 1'b1;
    rd_exp = 32'h0;
    case (avs_address)
      A_CFG: rd_exp = {30'h0, cfg_r};
      A_E1: rd_exp = {27'h0, en_r[4:0]};
      A_E2: rd_exp = {27'h0, en_r[9:5]};
      A_STA, A_MSK: rd_chk = 1'b0;
      default: rd_exp = 32'h0;
    endcase
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd_wait;
    avs_waitrequest;
  endsequence
  sequence s_rd_done;
    !avs_waitrequest && avs_readdata[31:8] == 24'h0;
  endsequence
  property p_rd_answer;
    $rose(avs_read) |-> s_rd_wait ##1 s_rd_done;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer timing wrong");
  property p_wr_nowait;
    avs_write && !avs_read |-> !avs_waitrequest;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_wait_rd;
    avs_waitrequest |-> avs_read;
  endproperty
  a_wait_rd: assert property (p_wait_rd) else $error("stall without read");
  property p_rd_data;
    avs_read && !avs_waitrequest && rd_chk |-> avs_readdata == rd_exp;
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data wrong");
  property p_echo_on;
    $past(rst_n_i) |-> ((echo_pin_o ^ $past(echo_src_gpio_o)) & $past(sel)) == 10'h0;
  endproperty
  a_echo_on: assert property (p_echo_on) else $error("echo lane wrong");
  property p_echo_off;
    $past(rst_n_i) |-> ((echo_pin_o ^ $past(echo_out_data_i)) & ~$past(sel)) == 10'h0;
  endproperty
  a_echo_off: assert property (p_echo_off) else $error("plain lane wrong");
  property p_sync;
    $past(rst_n_i, 2) && $past(rst_n_i) |-> echo_src_gpio_o == $past(echo_src_pin_i, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("source sync wrong");
  property p_wake_open;
    $past(rst_n_i) |-> wake_open_o == $past(cfg_r & wake_gpio_func_i);
  endproperty
  a_wake_open: assert property (p_wake_open) else $error("wake open wrong");
  property p_wake_lvl;
    $past(rst_n_i) |->
      wake_level_o == $past(echo_src_gpio_o[2:1] & cfg_r & wake_gpio_func_i);
  endproperty
  a_wake_lvl: assert property (p_wake_lvl) else $error("wake level wrong");
  property p_alt;
    $past(rst_n_i) |-> alt_irq_en_o == $past(alt_func_sel_i);
  endproperty
  a_alt: assert property (p_alt) else $error("alt enable wrong");
  property p_irq_mask;
    mask_r == 8'h00 |-> !irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
endmodule
bind gwe_top gwe_top_props #(.N_ALT(N_ALT)) i_gwe_top_props (.*);
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the wake-interrupt and echo configuration block.
// Assumes the checker is bound in by its own file.
`include "gwe_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [15:0] idx;
    logic [7:0]  wd;
    logic [7:0]  ex;
  } gwe_row_s;
  localparam logic [15:0] CFG = `GWE_IDX_EXT_IRQ_CONFIG;
  localparam logic [15:0] E1  = `GWE_IDX_ECHO_ENABLE_ONE;
  localparam logic [15:0] E2  = `GWE_IDX_ECHO_ENABLE_TWO;
  localparam logic [15:0] STA = `GWE_IDX_IRQ_STATUS;
  localparam logic [15:0] MSK = `GWE_IDX_IRQ_MASK;
  localparam gwe_row_s ROWS [7] = '{
    '{CFG, 8'hFF, 8'h03}, '{E1, 8'hFF, 8'h1F}, '{E2, 8'hFF, 8'h1F}, '{E1, 8'hA0, 8'h00},
    '{CFG, 8'h02, 8'h02}, '{E2, 8'h0A, 8'h0A}, '{16'hFF0A, 8'h5A, 8'h00}};
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [17:0] avs_address = 18'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [9:0]  src = 10'h3FF;
  logic [9:0]  dest = 10'h3FF;
  logic [9:0]  outd = 10'h0;
  logic [1:0]  func = 2'h3;
  logic [1:0]  alt_pin = 2'h0;
  logic [1:0]  alt_sel = 2'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq_o;
  logic [9:0]  echo_pin_o;
  logic [9:0]  echo_src_gpio_o;
  logic [1:0]  wake_open_o;
  logic [1:0]  wake_level_o;
  logic [1:0]  alt_irq_en_o;
  logic [31:0] q;
  logic [9:0]  oh;
  int          failures = 0;
  int          n_compared = 0;
  always #5 clk_i = ~clk_i;
  gwe_top #(.N_ALT(2)) i_gwe_top (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_o(irq_o),
    .echo_src_pin_i(src), .echo_dest_gpio_i(dest), .echo_out_data_i(outd),
    .echo_pin_o(echo_pin_o), .echo_src_gpio_o(echo_src_gpio_o), .wake_gpio_func_i(func),
    .wake_open_o(wake_open_o), .wake_level_o(wake_level_o), .alt_pin_i(alt_pin),
    .alt_func_sel_i(alt_sel), .alt_irq_en_o(alt_irq_en_o));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic rd, input logic [15:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    check("waitrequest", 32'h0, {31'h0, avs_waitrequest});
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b0, idx, d);
  endtask
  task automatic rd(input logic [15:0] idx);
    bus(1'b1, idx, 8'h00);
  endtask
  task automatic hop(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic chk_reset;
    rd(CFG);
    check("cfg_reset", 32'h0, q);
    rd(E1);
    check("echo_one_reset", 32'h0, q);
    rd(E2);
    check("echo_two_reset", 32'h0, q);
  endtask
  task automatic end_of_test;
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk_reset;
    foreach (ROWS[i]) begin
      wr(ROWS[i].idx, ROWS[i].wd);
      rd(ROWS[i].idx);
      check("readback", {24'h0, ROWS[i].ex}, q);
    end
    avs_byteenable <= 4'hE;
    wr(CFG, 8'h01);
    avs_byteenable <= 4'hF;
    rd(CFG);
    check("lane_off_write", 32'h2, q);
    for (int i = 0; i < 10; i++) begin
      oh = 10'h1 << i;
      wr(E1, {3'h0, oh[4:0]});
      wr(E2, {3'h0, oh[9:5]});
      hop(1);
      check("echo_walk", {22'h0, oh}, {22'h0, echo_pin_o});
      @(posedge clk_i);
    end
    wr(E1, 8'h1F);
    wr(E2, 8'h1F);
    src <= 10'h0;
    outd <= 10'h2AA;
    dest <= 10'h155;
    hop(3);
    check("echo_mix", 32'h2AA, {22'h0, echo_pin_o});
    @(posedge clk_i);
    src <= 10'h3FF;
    wr(E1, 8'h00);
    hop(3);
    check("echo_off", 32'h3EA, {22'h0, echo_pin_o});
    @(posedge clk_i);
    for (int k = 0; k < 4; k++) begin
      wr(CFG, 8'(k));
      hop(1);
      check("wake_open", 32'(k), {30'h0, wake_open_o});
      check("wake_level", 32'(k), {30'h0, wake_level_o});
      @(posedge clk_i);
    end
    func <= 2'h1;
    hop(1);
    check("wake_func", 32'h1, {30'h0, wake_open_o});
    @(posedge clk_i);
    func <= 2'h3;
    hop(2);
    @(posedge clk_i);
    wr(STA, 8'hFF);
    src[1] <= 1'b0;
    hop(6);
    check("irq_masked", 32'h0, {31'h0, irq_o});
    @(posedge clk_i);
    rd(STA);
    check("status", 32'h1, q);
    wr(MSK, 8'h01);
    hop(0);
    check("irq_set", 32'h1, {31'h0, irq_o});
    @(posedge clk_i);
    wr(STA, 8'h01);
    hop(0);
    check("irq_clear", 32'h0, {31'h0, irq_o});
    @(posedge clk_i);
    alt_sel <= 2'h1;
    hop(1);
    check("alt_irq_en", 32'h1, {30'h0, alt_irq_en_o});
    @(posedge clk_i);
    alt_pin <= 2'h1;
    hop(6);
    @(posedge clk_i);
    rd(STA);
    check("alt_status", 32'h4, q);
    rst_n_i <= 1'b0;
    hop(0);
    check("reset_pins", 32'h0, {22'h0, echo_pin_o});
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk_reset;
    end_of_test;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    $display("MISMATCH watchdog expected finish seen timeout");
    end_of_test;
  end
endmodule
`default_nettype wire
